// ---- core/nir_pkg.sv ----
// nir_pkg: constants for the node identity / rom window register bank
// assumes: 32-bit ahb-lite register bus, 100 MHz system clock
package nir_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] NIR_OFF_ID_UPPER = 8'h24;
    localparam logic [7:0] NIR_OFF_ID_LOWER = 8'h28;
    localparam logic [7:0] NIR_OFF_ROM_BASE = 8'h34;
    localparam logic [7:0] NIR_OFF_FAIL_LOW = 8'h38;
    localparam logic [7:0] NIR_OFF_FAIL_HIGH = 8'h3C;
    localparam logic [7:0] NIR_OFF_IRQ_STAT = 8'h60;
    localparam logic [7:0] NIR_OFF_IRQ_MASK = 8'h64;
    localparam logic [7:0] NIR_OFF_ID_STAT = 8'h68;
    // ************************************************************
    // reset values and fields
    // ************************************************************
    localparam logic [31:0] NIR_ID_RESET = 32'h00000000;
    localparam logic [31:0] NIR_ROM_BASE_RESET = 32'h00000000;
    localparam logic [31:0] NIR_ROM_BASE_MASK = 32'hFFFFFC00;
    localparam int NIR_ROM_LOW_BITS = 10;
    localparam logic [47:0] NIR_ROM_FIRST = 48'hFFFFF0000400;
    localparam logic [47:0] NIR_ROM_LAST = 48'hFFFFF00007FF;
    localparam int NIR_MAKER_HI = 31;
    localparam int NIR_MAKER_LO = 8;
    localparam int NIR_IRQ_BITS = 2;
    localparam int NIR_IRQ_LOADED = 0;
    localparam int NIR_IRQ_FAIL = 1;
    localparam logic [1:0] NIR_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] NIR_HSIZE_WORD = 3'h2;
    // ************************************************************
    // load sequencer states
    // ************************************************************
    typedef enum logic [2:0] {
        NIR_ST_IDLE = 3'b001,
        NIR_ST_LOAD = 3'b010,
        NIR_ST_LOCK = 3'b100
    } nir_state_t;
endpackage

// ---- core/nir_capture.sv ----
// nir_capture: posted-write failure capture (offset and requester)
// assumes: failure strobe comes from logic on clk_sys_in
`timescale 1ns/1ps
module nir_capture (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // failure event
    input wire logic fail_valid_in,
    input wire logic [47:0] fail_offset_in,
    input wire logic [15:0] fail_node_in,
    // captured contents
    output logic [31:0] fail_low_out,
    output logic [31:0] fail_high_out
);
    // ************************************************************
    // capture registers
    // ************************************************************
    logic [31:0] low_q;
    logic [31:0] high_q;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            low_q <= 32'h00000000;
            high_q <= 32'h00000000;
        end else if (fail_valid_in) begin
            low_q <= fail_offset_in[31:0];
            high_q <= {fail_node_in, fail_offset_in[47:32]};
        end
    end

    assign fail_low_out = low_q;
    assign fail_high_out = high_q;
endmodule

// ---- core/nir_regs.sv ----
// nir_regs: node identity, rom window and failed-write register bank
// assumes: single ahb-lite master, word transfers; serial rom reader
// outside delivers a loaded identifier as a one-cycle strobe
`timescale 1ns/1ps
module nir_regs (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // pci reset and serial rom
    input wire logic pci_reset_in,
    input wire logic rom_present_in,
    input wire logic rom_load_valid_in,
    input wire logic [63:0] rom_load_id_in,
    output logic rom_load_req_out,
    // configuration rom read redirection
    input wire logic rom_read_valid_in,
    input wire logic [47:0] rom_read_offset_in,
    output logic rom_read_hit_out,
    output logic [31:0] rom_read_addr_out,
    // posted write failure
    input wire logic fail_valid_in,
    input wire logic [47:0] fail_offset_in,
    input wire logic [15:0] fail_node_in,
    // identity fields
    output logic [23:0] node_maker_code_out,
    output logic [7:0] unit_serial_upper_out,
    output logic [31:0] unit_serial_lower_out,
    output logic id_valid_out,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // interrupt
    output logic irq_out
);
    import nir_pkg::*;
    // ************************************************************
    // state
    // ************************************************************
    nir_state_t state_q;
    logic [31:0] id_upper_q;
    logic [31:0] id_lower_q;
    logic [31:0] rom_base_q;
    logic [NIR_IRQ_BITS-1:0] irq_stat_q;
    logic [NIR_IRQ_BITS-1:0] irq_mask_q;
    logic [31:0] fail_low;
    logic [31:0] fail_high;
    logic [31:0] hrdata_q;
    logic pci_s1_q;
    logic pci_s2_q;
    logic pci_s3_q;
    logic prs_s1_q;
    logic prs_s2_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic rd_go;
    logic wr_go;
    logic stat_rd;
    logic pci_rise;
    logic [NIR_IRQ_BITS-1:0] irq_set;

    // ************************************************************
    // decode helper
    // ************************************************************
    function automatic logic [31:0] nir_read(input logic [7:0] off,
            input logic [31:0] up, input logic [31:0] lo,
            input logic [31:0] base, input logic [31:0] fl,
            input logic [31:0] fh, input logic [1:0] st,
            input logic [1:0] mk, input logic lock);
        logic [31:0] v;
        v = 32'h00000000;
        unique case (off)
            NIR_OFF_ID_UPPER: v = up;
            NIR_OFF_ID_LOWER: v = lo;
            NIR_OFF_ROM_BASE: v = base & NIR_ROM_BASE_MASK;
            NIR_OFF_FAIL_LOW: v = fl;
            NIR_OFF_FAIL_HIGH: v = fh;
            NIR_OFF_IRQ_STAT: v = {30'h00000000, st};
            NIR_OFF_IRQ_MASK: v = {30'h00000000, mk};
            NIR_OFF_ID_STAT: v = {31'h00000000, lock};
            default: v = 32'h00000000;
        endcase
        return v;
    endfunction

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            pci_s1_q <= 1'b0;
            pci_s2_q <= 1'b0;
            pci_s3_q <= 1'b0;
            prs_s1_q <= 1'b0;
            prs_s2_q <= 1'b0;
        end else begin
            pci_s1_q <= pci_reset_in;
            pci_s2_q <= pci_s1_q;
            pci_s3_q <= pci_s2_q;
            prs_s1_q <= rom_present_in;
            prs_s2_q <= prs_s1_q;
        end
    end

    // end of pci reset pulse
    assign pci_rise = pci_s3_q && !pci_s2_q;

    // ************************************************************
    // identifier load sequencer
    // ************************************************************
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            state_q <= NIR_ST_IDLE;
        end else begin
            unique case (state_q)
                NIR_ST_IDLE: begin
                    if (pci_rise && prs_s2_q) begin
                        state_q <= NIR_ST_LOAD;
                    end
                end
                NIR_ST_LOAD: begin
                    if (rom_load_valid_in) begin
                        state_q <= NIR_ST_LOCK;
                    end
                end
                NIR_ST_LOCK: begin
                    state_q <= NIR_ST_LOCK;
                end
                default: state_q <= NIR_ST_IDLE;
            endcase
        end
    end

    assign rom_load_req_out = (state_q == NIR_ST_LOAD);
    assign id_valid_out = (state_q == NIR_ST_LOCK);

    // identifier words: written only by the rom load, never by the bus
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            id_upper_q <= NIR_ID_RESET;
            id_lower_q <= NIR_ID_RESET;
        end else if (state_q == NIR_ST_LOAD && rom_load_valid_in) begin
            id_upper_q <= rom_load_id_in[63:32];
            id_lower_q <= rom_load_id_in[31:0];
        end
    end

    // field split of the identifier
    assign node_maker_code_out = id_upper_q[NIR_MAKER_HI:NIR_MAKER_LO];
    assign unit_serial_upper_out = id_upper_q[NIR_MAKER_LO-1:0];
    assign unit_serial_lower_out = id_lower_q;

    // ************************************************************
    // configuration rom read redirection
    // ************************************************************
    logic rom_hit;
    assign rom_hit = rom_read_valid_in
        && rom_read_offset_in >= NIR_ROM_FIRST
        && rom_read_offset_in <= NIR_ROM_LAST;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            rom_read_hit_out <= 1'b0;
            rom_read_addr_out <= 32'h00000000;
        end else begin
            rom_read_hit_out <= rom_hit;
            if (rom_hit) begin
                rom_read_addr_out <= (rom_base_q & NIR_ROM_BASE_MASK)
                    + {22'h000000,
                       rom_read_offset_in[NIR_ROM_LOW_BITS-1:0]};
            end
        end
    end

    // ************************************************************
    // failed posted write capture
    // ************************************************************
    nir_capture u_capture (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .fail_valid_in(fail_valid_in),
        .fail_offset_in(fail_offset_in),
        .fail_node_in(fail_node_in),
        .fail_low_out(fail_low),
        .fail_high_out(fail_high)
    );

    // ************************************************************
    // ahb-lite slave
    // ************************************************************
    assign rd_go = hsel && hready && htrans == NIR_HTRANS_NONSEQ && !hwrite;
    assign wr_go = hsel && hready && htrans == NIR_HTRANS_NONSEQ && hwrite;
    assign stat_rd = rd_go && haddr[7:0] == NIR_OFF_IRQ_STAT
        && haddr[31:8] == 24'h000000;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= wr_go && haddr[31:8] == 24'h000000;
            wr_addr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            hrdata_q <= 32'h00000000;
        end else if (rd_go) begin
            if (haddr[31:8] == 24'h000000) begin
                hrdata_q <= nir_read(haddr[7:0], id_upper_q, id_lower_q,
                    rom_base_q, fail_low, fail_high, irq_stat_q,
                    irq_mask_q, id_valid_out);
            end else begin
                hrdata_q <= 32'h00000000;
            end
        end
    end

    // writable registers; identifier offsets ignore writes
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            rom_base_q <= NIR_ROM_BASE_RESET;
            irq_mask_q <= '0;
        end else if (wr_pend_q) begin
            if (wr_addr_q == NIR_OFF_ROM_BASE) begin
                rom_base_q <= hwdata & NIR_ROM_BASE_MASK;
            end
            if (wr_addr_q == NIR_OFF_IRQ_MASK) begin
                irq_mask_q <= hwdata[NIR_IRQ_BITS-1:0];
            end
        end
    end

    // ************************************************************
    // interrupt status: set wins over read clear
    // ************************************************************
    assign irq_set[NIR_IRQ_LOADED] = state_q == NIR_ST_LOAD
        && rom_load_valid_in;
    assign irq_set[NIR_IRQ_FAIL] = fail_valid_in;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (stat_rd ? '0 : irq_stat_q) | irq_set;
        end
    end

    assign irq_out = |(irq_stat_q & irq_mask_q);
endmodule

// ---- tb/nir_regs_properties.sv ----
// nir_regs_properties: port-level checks of the register bank
// assumes: bound to nir_regs, one clock, synchronous reset
`timescale 1ns/1ps
module nir_regs_chk
import nir_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // rom load and read
    input wire logic rom_load_valid_in,
    input wire logic [63:0] rom_load_id_in,
    input wire logic rom_load_req_out,
    input wire logic rom_read_valid_in,
    input wire logic [47:0] rom_read_offset_in,
    input wire logic rom_read_hit_out,
    input wire logic [31:0] rom_read_addr_out,
    // identity
    input wire logic [23:0] node_maker_code_out,
    input wire logic [7:0] unit_serial_upper_out,
    input wire logic [31:0] unit_serial_lower_out,
    input wire logic id_valid_out,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    // ********************************
    // helpers and assertions
    // ********************************
    logic rd_q;
    logic [7:0] ad_q;
    logic [9:0] off_q;
    logic in_rng;
    assign in_rng = rom_read_offset_in >= NIR_ROM_FIRST &&
        rom_read_offset_in <= NIR_ROM_LAST;
    always_ff @(posedge clk_sys_in) begin
        rd_q <= resetn_in && hsel && hready && !hwrite &&
            htrans == NIR_HTRANS_NONSEQ;
        ad_q <= haddr[7:0];
        off_q <= rom_read_offset_in[9:0];
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    AST_ID_ZERO: assert property (
        !id_valid_out |-> {node_maker_code_out, unit_serial_upper_out,
        unit_serial_lower_out} == 64'h0)
        else $error("identity not zero before load");
    AST_LOAD_VALID: assert property (
        rom_load_valid_in && rom_load_req_out |=> id_valid_out)
        else $error("load not taken");
    AST_LOAD_DATA: assert property (
        rom_load_valid_in && rom_load_req_out |=> {node_maker_code_out,
        unit_serial_upper_out, unit_serial_lower_out} ==
        $past(rom_load_id_in))
        else $error("loaded identity wrong");
    AST_LOCK: assert property (
        id_valid_out |=> id_valid_out && $stable(unit_serial_lower_out)
        && $stable(node_maker_code_out) && $stable(unit_serial_upper_out))
        else $error("identity changed after lock");
    AST_HIT: assert property (
        rom_read_valid_in && in_rng |=> rom_read_hit_out &&
        rom_read_addr_out[9:0] == off_q)
        else $error("rom read not redirected");
    AST_MISS: assert property (
        !(rom_read_valid_in && in_rng) |=> !rom_read_hit_out)
        else $error("stray rom read hit");
    AST_BASE_RSVD: assert property (
        rd_q && ad_q == NIR_OFF_ROM_BASE |-> hrdata[9:0] == 10'h000)
        else $error("base low bits not zero");
    AST_UP_READ: assert property (
        rd_q && ad_q == NIR_OFF_ID_UPPER |-> hrdata ==
        {node_maker_code_out, unit_serial_upper_out})
        else $error("upper word read wrong");
    cover property (rom_load_valid_in && rom_load_req_out);
    cover property (rom_read_valid_in && in_rng);
    cover property (rd_q && ad_q == NIR_OFF_ROM_BASE);
endmodule
bind nir_regs nir_regs_chk nir_regs_chk_i (.*);

// ---- tb/nir_rom_model.sv ----
// nir_rom_model: serial rom reader answering load requests
// assumes: request level from the bank, one clock
`timescale 1ns/1ps
module nir_rom_model
import nir_pkg::*;
#(
    parameter logic [63:0] ROM_ID = 64'h0123456789ABCDEF, // arbitrary
    parameter int DELAY = 5
) (
    // clock
    input wire logic clk_sys_in,
    // control
    input wire logic req_in,
    input wire logic stray_in,
    // load strobe
    output logic valid_out,
    output logic [63:0] id_out
);
    // ********************************
    // answer after a delay
    // ********************************
    int cnt = 0;
    initial begin
        valid_out = 1'b0;
        id_out = ~ROM_ID;
    end
    always @(posedge clk_sys_in) begin
        valid_out <= stray_in || (req_in && cnt == DELAY);
        id_out <= (!stray_in && req_in && cnt == DELAY) ? ROM_ID : ~ROM_ID;
        cnt <= req_in ? cnt + 1 : 0;
    end
endmodule

// ---- tb/nir_regs_tb.sv ----
// nir_regs_tb: register bank bench over ahb-lite
// assumes: design, checker and rom model compiled first
`timescale 1ns/1ps
module nir_regs_tb;
    import nir_pkg::*;
    localparam logic [63:0] ID = 64'h0123456789ABCDEF; // arbitrary
    logic clk_sys_in, resetn_in, pci_reset_in, stray, present;
    logic rom_load_valid_in, rom_load_req_out, id_valid_out;
    logic [63:0] rom_load_id_in;
    logic rom_read_valid_in, rom_read_hit_out;
    logic [47:0] rom_read_offset_in, fail_offset_in;
    logic [31:0] rom_read_addr_out, unit_serial_lower_out;
    logic fail_valid_in, hsel, hwrite, hreadyout, hresp, irq_out;
    logic [15:0] fail_node_in;
    logic [23:0] node_maker_code_out;
    logic [7:0] unit_serial_upper_out;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    int fails, total_checks, cycles;
    nir_regs nir_regs_i (.*, .rom_present_in(present),
        .hsize(NIR_HSIZE_WORD), .hready(hreadyout));
    nir_rom_model #(.ROM_ID(ID)) nir_rom_model_i (.clk_sys_in(clk_sys_in),
        .req_in(rom_load_req_out), .stray_in(stray),
        .valid_out(rom_load_valid_in), .id_out(rom_load_id_in));
    // ********************************
    // tasks
    // ********************************
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= NIR_HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge clk_sys_in);
        while (hreadyout !== 1'b1) @(posedge clk_sys_in);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys_in);
        while (hreadyout !== 1'b1) @(posedge clk_sys_in);
        r = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask
    task automatic rrd(input logic [47:0] o, input logic h,
            input logic [31:0] a);
        rom_read_valid_in <= 1'b1;
        rom_read_offset_in <= o;
        @(posedge clk_sys_in);
        rom_read_valid_in <= 1'b0;
        @(posedge clk_sys_in);
        chk({31'h0, rom_read_hit_out}, {31'h0, h});
        if (h) chk(rom_read_addr_out, a);
    endtask
    task automatic irq(input logic e);
        repeat (2) @(posedge clk_sys_in);
        chk({31'h0, irq_out}, {31'h0, e});
    endtask
    // ********************************
    // sequence
    // ********************************
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            close_out;
        end
    end
    initial begin
        {resetn_in, pci_reset_in, stray, hsel, hwrite, htrans} = '0;
        {haddr, hwdata, rom_read_valid_in, rom_read_offset_in} = '0;
        {fail_valid_in, fail_offset_in, fail_node_in} = '0;
        present = 1'b1;
        repeat (4) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        @(posedge clk_sys_in);
        rd(NIR_OFF_ID_UPPER, 32'h0);
        rd(NIR_OFF_ID_LOWER, 32'h0);
        rd(NIR_OFF_ROM_BASE, 32'h0);
        wr(NIR_OFF_ID_UPPER, 32'hFFFFFFFF);
        rd(NIR_OFF_ID_UPPER, 32'h0);
        wr(NIR_OFF_ROM_BASE, 32'h123457FF);
        rd(NIR_OFF_ROM_BASE, 32'h12345400);
        rrd(48'hFFFFF0000400, 1'b1, 32'h12345400);
        rrd(48'hFFFFF00007FF, 1'b1, 32'h123457FF);
        rrd(48'hFFFFF00003FF, 1'b0, 32'h0);
        rrd(48'hFFFFF0000800, 1'b0, 32'h0);
        wr(NIR_OFF_IRQ_MASK, 32'h0);
        fail_valid_in <= 1'b1;
        fail_offset_in <= 48'hABCD12345678;
        fail_node_in <= 16'hFFC1;
        @(posedge clk_sys_in);
        fail_valid_in <= 1'b0;
        rd(NIR_OFF_FAIL_LOW, 32'h12345678);
        rd(NIR_OFF_FAIL_HIGH, 32'hFFC1ABCD);
        irq(1'b0);
        wr(NIR_OFF_FAIL_LOW, 32'h0);
        rd(NIR_OFF_FAIL_LOW, 32'h12345678);
        rd(NIR_OFF_FAIL_HIGH, 32'hFFC1ABCD);
        wr(NIR_OFF_IRQ_MASK, 32'h3);
        irq(1'b1);
        rd(NIR_OFF_IRQ_STAT, 32'h2);
        irq(1'b0);
        pci_reset_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        pci_reset_in <= 1'b0;
        for (int i = 0; i < 60 && id_valid_out !== 1'b1; i++)
            @(posedge clk_sys_in);
        chk({31'h0, id_valid_out}, 32'h1);
        rd(NIR_OFF_ID_UPPER, ID[63:32]);
        chk({node_maker_code_out, unit_serial_upper_out}, ID[63:32]);
        rd(NIR_OFF_ID_LOWER, ID[31:0]);
        irq(1'b1);
        rd(NIR_OFF_IRQ_STAT, 32'h1);
        stray <= 1'b1;
        @(posedge clk_sys_in);
        stray <= 1'b0;
        wr(NIR_OFF_ID_LOWER, 32'h0);
        rd(NIR_OFF_ID_LOWER, ID[31:0]);
        rd(NIR_OFF_ID_UPPER, ID[63:32]);
        rd(8'h70, 32'h0);
        resetn_in <= 1'b0;
        present <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        @(posedge clk_sys_in);
        rd(NIR_OFF_ID_UPPER, 32'h0);
        rd(NIR_OFF_ID_LOWER, 32'h0);
        pci_reset_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        pci_reset_in <= 1'b0;
        repeat (10) @(posedge clk_sys_in);
        chk({31'h0, id_valid_out}, 32'h0);
        rd(NIR_OFF_ID_UPPER, 32'h0);
        close_out;
    end
endmodule
